/* File: hdl/ulpmr_phy.sv */
/*
 * Transceiver end: line-state debug register, test byte, power
 * control register, address decode and BVALID edge events.
 * Assumes the link holds a request until it sees ack.
 */
`timescale 1ns/1ps
module ulpmr_phy (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // link side
   ulpmr_if.phy      bus,
   // analog front-end status
   input  wire logic [1:0] line_state,
   input  wire logic       bvalid,
   // shared reset / power-switch pin
   input  wire logic       shared_pin_in,
   output logic            shared_pin_out,
   output logic            shared_pin_oe_b,
   // power-switch request, reset seen on the pin, test byte and power control values
   input  wire logic       vbus_drive,
   output logic            pin_reset_low,
   output logic [7:0]      scratch_value,
   output logic [7:0]      power_control
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] scratch;
      logic [7:0] pwr;
      logic       bvalid_seen;
      logic       ack;
      logic [7:0] rdata;
      logic       evt;
      logic       pin_out;
      logic       pin_oe_b;
      logic       pin_rst;
   } ulpmr_phy_s;

   ulpmr_phy_s st_q;
   ulpmr_phy_s st_d;

   logic       take;
   logic       mapped;
   logic [7:0] eff_addr;

   // ----------------------------------------------------------------
   // decode and next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      take     = bus.req && !st_q.ack;
      eff_addr = bus.addr;
      // extended space above the alias window is undefined; act on nothing
      mapped   = !(bus.ext &&
                   (bus.addr > ulpmr_pkg::EXT_ALIAS_HI_ADDR)); // RQ7
      st_d.ack = take;
      if (take) begin
         st_d.rdata = 8'h00;
         if (mapped && !bus.wr) begin
            if (eff_addr == ulpmr_pkg::LINE_STATE_ADDR) begin
               st_d.rdata = {6'h00, line_state}; // RQ1
            end else if (eff_addr >= ulpmr_pkg::SCRATCH_WR_ADDR &&
                         eff_addr <= ulpmr_pkg::SCRATCH_CLR_ADDR) begin
               st_d.rdata = st_q.scratch; // RQ3
            end else if (eff_addr >= ulpmr_pkg::PWR_WR_ADDR &&
                         eff_addr <= ulpmr_pkg::PWR_CLR_ADDR) begin
               st_d.rdata = st_q.pwr; // RQ15 RQ6
            end
            // 19h..2Eh, 2Fh and other vendor slots read as zero RQ4 RQ5
         end
         if (mapped && bus.wr) begin
            unique case (eff_addr)
               ulpmr_pkg::SCRATCH_WR_ADDR: begin
                  st_d.scratch = bus.wdata; // RQ3
               end
               ulpmr_pkg::SCRATCH_SET_ADDR: begin
                  st_d.scratch = st_q.scratch | bus.wdata; // RQ16
               end
               ulpmr_pkg::SCRATCH_CLR_ADDR: begin
                  st_d.scratch = st_q.scratch & ~bus.wdata; // RQ16
               end
               ulpmr_pkg::PWR_WR_ADDR: begin
                  st_d.pwr = bus.wdata; // RQ15
               end
               ulpmr_pkg::PWR_SET_ADDR: begin
                  st_d.pwr = st_q.pwr | bus.wdata; // RQ16
               end
               ulpmr_pkg::PWR_CLR_ADDR: begin
                  st_d.pwr = st_q.pwr & ~bus.wdata; // RQ16
               end
               // unimplemented, escape and spare vendor slots ignored
               default: begin
                  st_d.pwr = st_q.pwr; // RQ4 RQ5
               end
            endcase
         end
      end

      // bvalid edges, each gated by its own enable
      st_d.bvalid_seen = bvalid;
      st_d.evt = (st_q.pwr[ulpmr_pkg::PWR_BV_FALL_BIT] &&
                  st_q.bvalid_seen && !bvalid) || // RQ9
                 (st_q.pwr[ulpmr_pkg::PWR_BV_RISE_BIT] &&
                  !st_q.bvalid_seen && bvalid); // RQ10

      // shared pin role: reset input or driven power switch
      if (st_q.pwr[ulpmr_pkg::PWR_ROLE_BIT]) begin
         st_d.pin_oe_b = 1'b0; // RQ12
         st_d.pin_out  = !vbus_drive;
         st_d.pin_rst  = 1'b0;
      end else begin
         st_d.pin_oe_b = 1'b1; // RQ12
         st_d.pin_out  = 1'b1;
         st_d.pin_rst  = !shared_pin_in;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q.scratch     <= ulpmr_pkg::SCRATCH_RESET; // RQ2
         st_q.pwr         <= ulpmr_pkg::PWR_RESET; // RQ15
         st_q.bvalid_seen <= 1'b0;
         st_q.ack         <= 1'b0;
         st_q.rdata       <= 8'h00;
         st_q.evt         <= 1'b0;
         st_q.pin_out     <= 1'b1;
         st_q.pin_oe_b    <= 1'b1;
         st_q.pin_rst     <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // scratch feeds nothing but its own readback and scratch_value
   assign bus.ack            = st_q.ack;
   assign bus.rdata          = st_q.rdata;
   assign bus.evt            = st_q.evt;
   assign bus.evt_alt_int    = st_q.evt; // RQ9 RQ10
   assign bus.evt_line_state = line_state;
   assign shared_pin_out     = st_q.pin_out;
   assign shared_pin_oe_b    = st_q.pin_oe_b;
   assign pin_reset_low      = st_q.pin_rst;
   assign scratch_value      = st_q.scratch;
   assign power_control      = st_q.pwr;

endmodule

/* File: pkg/ulpmr_pkg.sv */
/*
 * Constants shared by both ends of the register link
 * of the transceiver's upper register map.
 * Assumes a single 60 MHz-class clock common to both ends.
 */
// Behaviour
// RQ1 - 15h reads live line state, upper zero
// RQ2 - eight-bit test byte, reset 00h, no effect
// RQ3 - test byte: write 16h, set 17h, clear 18h
// RQ4 - addresses 19h..2Eh do nothing
// RQ5 - 2Fh is the extended-space escape code
// RQ6 - 30h..3Fh vendor space holds power control
// RQ7 - extended 00h..3Fh alias immediate registers
// RQ8 - link never accesses extended 40h..FFh
// RQ9 - BVALID fall with bit 3 sends event
// RQ10 - BVALID rise with bit 2 sends event
// RQ11 - OTG link uses session-valid, not BVALID enables
// RQ12 - bit 0 selects reset-in or switch-out pin
// RQ13 - link sets pin role for ganged switch
// RQ14 - link never writes ones to bits 7..4
// RQ15 - power control: write 3Dh, set 3Eh, clear 3Fh
// RQ16 - set ORs, clear AND-NOTs, others untouched
package ulpmr_pkg;
   localparam logic [7:0] LINE_STATE_ADDR = 8'h15;
   localparam logic [7:0] SCRATCH_WR_ADDR = 8'h16;
   localparam logic [7:0] SCRATCH_SET_ADDR = 8'h17;
   localparam logic [7:0] SCRATCH_CLR_ADDR = 8'h18;
   localparam logic [7:0] UNIMPL_LO_ADDR = 8'h19;
   localparam logic [7:0] UNIMPL_HI_ADDR = 8'h2E;
   localparam logic [7:0] EXT_ESCAPE_ADDR = 8'h2F;
   localparam logic [7:0] VENDOR_LO_ADDR = 8'h30;
   localparam logic [7:0] VENDOR_HI_ADDR = 8'h3F;
   localparam logic [7:0] PWR_WR_ADDR = 8'h3D;
   localparam logic [7:0] PWR_SET_ADDR = 8'h3E;
   localparam logic [7:0] PWR_CLR_ADDR = 8'h3F;
   localparam logic [7:0] EXT_ALIAS_HI_ADDR = 8'h3F;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam logic [7:0] PWR_RESET = 8'h00;
   localparam int PWR_ROLE_BIT = 0;
   localparam int PWR_BV_RISE_BIT = 2;
   localparam int PWR_BV_FALL_BIT = 3;
   localparam logic [7:0] PWR_RSVD_HI_MASK = 8'hF0;
   localparam int LINE_STATE_W = 2;
endpackage

/* File: pkg/ulpmr_if.sv */
/*
 * Register access and event channel between link and transceiver.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ulpmr_if;
   logic       req;
   logic       ext;
   logic [7:0] addr;
   logic       wr;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   logic       evt;
   logic       evt_alt_int;
   logic [1:0] evt_line_state;

   modport phy (input req, ext, addr, wr, wdata,
                output ack, rdata, evt, evt_alt_int, evt_line_state);
   modport link (output req, ext, addr, wr, wdata,
                 input ack, rdata, evt, evt_alt_int, evt_line_state);
endinterface

/* File: hdl/ulpmr_link.sv */
/*
 * Link end: turns user commands into register accesses, guards the
 * undefined extended space and reserved bits, reports BVALID events.
 * Assumes the transceiver answers each request with one ack pulse.
 */
`timescale 1ns/1ps
module ulpmr_link (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // transceiver side
   ulpmr_if.link     bus,
   // user command
   input  wire logic       cmd_valid,
   input  wire logic       cmd_ext,
   input  wire logic [7:0] cmd_addr,
   input  wire logic       cmd_write,
   input  wire logic [7:0] cmd_wdata,
   output logic            cmd_ready,
   // user response
   output logic            rsp_valid,
   output logic            rsp_refused,
   output logic [7:0]      rsp_data,
   // events
   output logic            bvalid_event
);

   typedef enum logic [1:0] {
      ULPMR_IDLE = 2'b01,
      ULPMR_BUSY = 2'b10
   } ulpmr_link_e;

   typedef struct packed {
      ulpmr_link_e fsm;
      logic        ext;
      logic [7:0]  addr;
      logic        wr;
      logic [7:0]  wdata;
      logic        rsp;
      logic        refused;
      logic [7:0]  data;
      logic        evt;
   } ulpmr_link_s;

   ulpmr_link_s st_q;
   ulpmr_link_s st_d;

   logic bad_ext;
   logic pwr_write;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d         = st_q;
      st_d.rsp     = 1'b0;
      st_d.refused = 1'b0;
      bad_ext      = cmd_ext &&
                     (cmd_addr > ulpmr_pkg::EXT_ALIAS_HI_ADDR); // RQ8
      pwr_write    = cmd_write &&
                     (cmd_addr == ulpmr_pkg::PWR_WR_ADDR ||
                      cmd_addr == ulpmr_pkg::PWR_SET_ADDR);
      // only BVALID-edge events surface; session events are elsewhere RQ11
      st_d.evt     = bus.evt && bus.evt_alt_int;
      unique case (st_q.fsm)
         ULPMR_IDLE: begin
            if (cmd_valid && bad_ext) begin
               st_d.rsp     = 1'b1; // RQ8
               st_d.refused = 1'b1;
               st_d.data    = 8'h00;
            end else if (cmd_valid) begin
               st_d.fsm   = ULPMR_BUSY;
               st_d.ext   = cmd_ext;
               st_d.addr  = cmd_addr;
               st_d.wr    = cmd_write;
               // reserved high bits never go out as ones to 3Dh/3Eh
               st_d.wdata = pwr_write ?
                            (cmd_wdata & ~ulpmr_pkg::PWR_RSVD_HI_MASK) :
                            cmd_wdata; // RQ14
            end
         end
         ULPMR_BUSY: begin
            if (bus.ack) begin
               st_d.fsm  = ULPMR_IDLE;
               st_d.rsp  = 1'b1;
               st_d.data = bus.rdata;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q.fsm     <= ULPMR_IDLE;
         st_q.ext     <= 1'b0;
         st_q.addr    <= 8'h00;
         st_q.wr      <= 1'b0;
         st_q.wdata   <= 8'h00;
         st_q.rsp     <= 1'b0;
         st_q.refused <= 1'b0;
         st_q.data    <= 8'h00;
         st_q.evt     <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // pin role (RQ13) is the user's write of bit 0 at 3Dh/3Eh, or its clear at 3Fh
   assign bus.req      = (st_q.fsm == ULPMR_BUSY);
   assign bus.ext      = st_q.ext;
   assign bus.addr     = st_q.addr;
   assign bus.wr       = st_q.wr;
   assign bus.wdata    = st_q.wdata;
   assign cmd_ready    = (st_q.fsm == ULPMR_IDLE);
   assign rsp_valid    = st_q.rsp;
   assign rsp_refused  = st_q.refused;
   assign rsp_data     = st_q.data;
   assign bvalid_event = st_q.evt;

endmodule

/* File: testbench/ulpmr_properties.sv */
/*
 * Checker on the register channel between link and transceiver.
 * Assumes one clock and the interface signals wired in as inputs.
 */
`timescale 1ns/1ps
module ulpmr_properties (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   // link requests
   input wire logic       req,
   input wire logic       ext,
   input wire logic [7:0] addr,
   input wire logic       wr,
   input wire logic [7:0] wdata,
   // transceiver answers
   input wire logic       ack,
   input wire logic [7:0] rdata,
   input wire logic       evt,
   input wire logic       evt_alt_int,
   input wire logic [1:0] evt_line_state
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic take_rd;
   assign take_rd = req && !ack && !wr;

   ack_follows_req_a: assert property (req && !ack |=> ack ##1 !ack)
      else $error("ack missing after request");
   ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
      else $error("ack without request");
   line_state_a: assert property (take_rd && addr == 8'h15
      |=> rdata == {6'h00, $past(evt_line_state)})
      else $error("line state read wrong");
   unimpl_zero_a: assert property (take_rd
      && addr inside {[8'h19:8'h2F]} |=> rdata == 8'h00)
      else $error("unimplemented read not zero");
   vendor_zero_a: assert property (take_rd
      && addr inside {[8'h30:8'h3C]} |=> rdata == 8'h00)
      else $error("empty vendor read not zero");
   ext_guard_a: assert property (!(req && ext && addr > 8'h3F))
      else $error("undefined extended access");
   rsvd_bits_a: assert property (req && wr
      && addr inside {8'h3D, 8'h3E} |-> wdata[7:4] == 4'h0)
      else $error("reserved power bits written");
   alt_int_a: assert property (evt |-> evt_alt_int ##1 !evt)
      else $error("event without alt flag");

   cover property (take_rd && addr == 8'h15);
   cover property (evt);
   cover property (req && wr && addr == 8'h3E);
endmodule

/* File: testbench/tb_top.sv */
/*
 * Bench joining link and transceiver ends through the interface.
 * Assumes commands are taken one at a time through the link end.
 */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic       e;
      logic [7:0] a;
      logic       w;
      logic [7:0] d;
      logic [7:0] x;
   } ulpmr_row_s;
   logic       mclk, rst_b, bvalid, vbus_drive, pin_ext, rf;
   logic [1:0] line_state;
   logic       cmd_valid, cmd_ext, cmd_write, cmd_ready, rsp_valid;
   logic       rsp_refused, bvalid_event, pin_reset_low;
   logic [7:0] cmd_addr, cmd_wdata, rd, rsp_data;
   logic [7:0] scratch_value, power_control, pin_pair;
   logic       shared_pin_out, shared_pin_oe_b;
   wire        shared_pin_in;
   int         bad_count, checks_done, ev_n, cyc;
   ulpmr_row_s rows [28];

   ulpmr_if ulpmr_if_inst ();
   ulpmr_phy ulpmr_phy_inst (.mclk(mclk), .rst_b(rst_b),
      .bus(ulpmr_if_inst), .line_state(line_state), .bvalid(bvalid),
      .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
      .shared_pin_oe_b(shared_pin_oe_b), .vbus_drive(vbus_drive),
      .pin_reset_low(pin_reset_low), .scratch_value(scratch_value),
      .power_control(power_control));
   ulpmr_link ulpmr_link_inst (.mclk(mclk), .rst_b(rst_b),
      .bus(ulpmr_if_inst), .cmd_valid(cmd_valid), .cmd_ext(cmd_ext),
      .cmd_addr(cmd_addr), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_refused(rsp_refused), .rsp_data(rsp_data),
      .bvalid_event(bvalid_event));
   ulpmr_properties ulpmr_properties_inst (.mclk(mclk), .rst_b(rst_b),
      .req(ulpmr_if_inst.req), .ext(ulpmr_if_inst.ext),
      .addr(ulpmr_if_inst.addr), .wr(ulpmr_if_inst.wr),
      .wdata(ulpmr_if_inst.wdata), .ack(ulpmr_if_inst.ack),
      .rdata(ulpmr_if_inst.rdata), .evt(ulpmr_if_inst.evt),
      .evt_alt_int(ulpmr_if_inst.evt_alt_int),
      .evt_line_state(ulpmr_if_inst.evt_line_state));

   // pin wire: transceiver drive wins, else the board level
   assign shared_pin_in = shared_pin_oe_b ? pin_ext : shared_pin_out;
   assign pin_pair      = {6'h00, shared_pin_oe_b, shared_pin_out};

   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (bvalid_event === 1'h1) ev_n++;
      if (cyc == 3000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic acc(input logic e, input logic [7:0] a, input logic w,
                      input logic [7:0] d);
      @(negedge mclk);
      cmd_valid = 1'h1;
      cmd_ext = e;
      cmd_addr = a;
      cmd_write = w;
      cmd_wdata = d;
      @(posedge mclk);
      @(negedge mclk);
      cmd_valid = 1'h0;
      for (int i = 0; i < 8 && rsp_valid !== 1'h1; i++) begin
         @(posedge mclk);
         #1;
      end
      rd = rsp_data;
      rf = rsp_refused;
   endtask

   task automatic ev_step(input logic [7:0] a, d, input logic b, int n);
      acc(1'h0, a, 1'h1, d);
      @(negedge mclk);
      bvalid = b;
      repeat (4) @(posedge mclk);
      #1;
      chk("event count", 8'(n), 8'(ev_n));
   endtask

   initial begin
      rows = '{
         {1'h0,8'h16,1'h0,8'h00,8'h00}, {1'h0,8'h16,1'h1,8'hA5,8'h00},
         {1'h0,8'h17,1'h0,8'h00,8'hA5}, {1'h0,8'h17,1'h1,8'h0A,8'h00},
         {1'h0,8'h18,1'h0,8'h00,8'hAF}, {1'h0,8'h18,1'h1,8'h81,8'h00},
         {1'h0,8'h16,1'h0,8'h00,8'h2E}, {1'h0,8'h15,1'h0,8'h00,8'h02},
         {1'h0,8'h15,1'h1,8'hFF,8'h00}, {1'h0,8'h15,1'h0,8'h00,8'h02},
         {1'h0,8'h19,1'h1,8'hFF,8'h00}, {1'h0,8'h2E,1'h1,8'hFF,8'h00},
         {1'h0,8'h19,1'h0,8'h00,8'h00}, {1'h0,8'h2E,1'h0,8'h00,8'h00},
         {1'h0,8'h2F,1'h1,8'hFF,8'h00}, {1'h0,8'h2F,1'h0,8'h00,8'h00},
         {1'h0,8'h16,1'h0,8'h00,8'h2E}, {1'h0,8'h3D,1'h0,8'h00,8'h00},
         {1'h0,8'h3D,1'h1,8'h0C,8'h00}, {1'h0,8'h3F,1'h0,8'h00,8'h0C},
         {1'h0,8'h3E,1'h1,8'h01,8'h00}, {1'h0,8'h3F,1'h1,8'h08,8'h00},
         {1'h0,8'h3E,1'h0,8'h00,8'h05}, {1'h0,8'h30,1'h0,8'h00,8'h00},
         {1'h1,8'h16,1'h0,8'h00,8'h2E}, {1'h1,8'h17,1'h1,8'h40,8'h00},
         {1'h0,8'h16,1'h0,8'h00,8'h6E}, {1'h1,8'h3E,1'h1,8'h02,8'h00}};
      {rst_b, bvalid, vbus_drive, cmd_valid, cmd_ext, cmd_write} = 6'h00;
      {cmd_addr, cmd_wdata} = 16'h0000;
      pin_ext = 1'h1;
      line_state = 2'h2;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst_b = 1'h1;
      foreach (rows[i]) begin
         acc(rows[i].e, rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) begin
            chk("read", rows[i].x, rd);
         end
      end
      // line state must be read live, not latched once
      @(negedge mclk);
      line_state = 2'h1;
      acc(1'h0, 8'h15, 1'h0, 8'h00);
      chk("line live", 8'h01, rd);
      chk("scratch", 8'h6E, scratch_value);
      chk("power", 8'h07, power_control);
      // ------------------------------
      // awkward cases
      // ------------------------------
      ev_step(8'h3D, 8'h00, 1'h1, 0);
      ev_step(8'h3D, 8'h08, 1'h0, 1);
      ev_step(8'h3E, 8'h04, 1'h1, 2);
      ev_step(8'h3F, 8'h08, 1'h0, 2);
      acc(1'h0, 8'h3D, 1'h1, 8'hFF);
      chk("power masked", 8'h0F, power_control);
      @(negedge mclk);
      vbus_drive = 1'h1;
      repeat (2) @(posedge mclk);
      #1;
      chk("switch pin", 8'h00, pin_pair);
      acc(1'h0, 8'h3F, 1'h1, 8'h01);
      @(negedge mclk);
      pin_ext = 1'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk("reset pin", 8'h03, {6'h00, shared_pin_oe_b, pin_reset_low});
      acc(1'h1, 8'h40, 1'h0, 8'h00);
      chk("refused", 8'h01, {7'h00, rf});
      chk("refused data", 8'h00, rd);
      chk("ready kept", 8'h01, {7'h00, cmd_ready});
      acc(1'h1, 8'hFF, 1'h1, 8'hFF);
      chk("scratch kept", 8'h6E, scratch_value);
      @(negedge mclk);
      rst_b = 1'h0;
      @(negedge mclk);
      chk("scratch reset", 8'h00, scratch_value);
      chk("power reset", 8'h00, power_control);
      rst_b = 1'h1;
      acc(1'h0, 8'h16, 1'h0, 8'h00);
      chk("read after reset", 8'h00, rd);
      finish_test();
   end
endmodule
